// ---- common/lpwm_cfg.svh ----
// Purpose: Constants for the port PWM intensity generator.
// Assumes: One 250 MHz clock; registers are written over a byte port.
// Notes: Included by the package and the testbench; definitions only.
`ifndef LPWM_CFG_SVH
`define LPWM_CFG_SVH

// ****************************************
// Register map and reset values
// ****************************************
`define LPWM_ADDR_MASTER 8'h0e
`define LPWM_ADDR_IND_FIRST 8'h10
`define LPWM_ADDR_IND_LAST 8'h17
`define LPWM_MASTER_RST 8'h00
`define LPWM_IND_RST 8'hff
`define LPWM_RD_UNMAPPED 8'h00

// ****************************************
// Field layout
// ****************************************
`define LPWM_NIB_W 4
`define LPWM_MST_MSB 7
`define LPWM_MST_LSB 4
`define LPWM_GLB_MSB 3
`define LPWM_GLB_LSB 0
`define LPWM_NPORT 16
`define LPWM_NOUT 17
`define LPWM_NREG 8

// ****************************************
// Timing
// ****************************************
`define LPWM_STATIC_CODE 4'hf
`define LPWM_OFF_CODE 4'h0
`define LPWM_CYC_LAST 4'hf
`define LPWM_SLOT_LAST 4'he
`define LPWM_CLK_NS 4
`define LPWM_STEP_NS 31250
`define LPWM_STEP_CYC (`LPWM_STEP_NS / `LPWM_CLK_NS)
`define LPWM_DIV_W 16
`endif

// ---- common/lpwm_pkg.sv ----
// Purpose: Types shared by the port PWM intensity generator.
// Assumes: lpwm_cfg.svh holds the numeric constants.
// Notes: Write and read requests travel as packed structs.
`include "lpwm_cfg.svh"
package lpwm_pkg;
    // Register write request.
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } lpwm_wr_t;
    // Register read request.
    typedef struct packed {
        logic en;
        logic [7:0] addr;
    } lpwm_rd_t;
endpackage

// ---- core/lpwm_core.sv ----
// Purpose: PWM intensity generator for sixteen open-drain port lines and
//          the extra output line.
// Assumes: Phase bits and the global select come from configuration
//          logic on the same clock; the serial protocol sits outside.
// Notes: Outputs are open drain, so only an output enable is driven.
// Functional notes
// - Master nibble zero: PWM off, every output static, global ignored.
// - Master nibble one to fifteen: PWM runs per intensity settings.
// - Global clear: each port line uses its own 4-bit setting; the extra line keeps the global nibble.
// - Individual setting fifteen: output static, no PWM.
// - Individual setting zero to fourteen: output modulated.
// - Global select applies to all outputs together, never a subset.
// - Global set: master register alone sets every output's intensity.
// - Individual registers ignored when PWM off or global selected.
// - Phase bit zero: low for n+1 sixteenths, else high impedance.
// - Phase bit one: high impedance n+1 sixteenths, else low.
// - Setting fifteen: static low for phase zero, released for one.
// - Period is 15 timeslots of 16 cycles, 240 steps, repeating.
// - Master value gates the setting during 1 to 15 timeslots.
// - Full-scale setting ignores master gating, follows phase bit.
// - Phase bit high releases the pin, low pulls it low.
`timescale 1ns/1ps
`default_nettype none
module lpwm_core
    import lpwm_pkg::*;
#(
    parameter logic [`LPWM_DIV_W-1:0] STEP_DIV =
        `LPWM_DIV_W'(`LPWM_STEP_CYC)
) (
    input wire logic clk,
    input wire logic nrst,
    input wire lpwm_wr_t wr,
    input wire lpwm_rd_t rd,
    output logic [7:0] rd_data,
    input wire logic global_select,
    input wire logic [`LPWM_NPORT-1:0] phase_output_bit,
    input wire logic extra_phase_bit,
    output logic [`LPWM_NPORT-1:0] port_line_out,
    output logic [`LPWM_NPORT-1:0] port_line_oe,
    output logic extra_output_line_out,
    output logic extra_output_line_oe
);
    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] master;
    logic [7:0] ind [`LPWM_NREG];
    logic [`LPWM_NIB_W-1:0] master_nib;
    logic [`LPWM_NIB_W-1:0] global_nib;
    logic pwm_on;
    logic [`LPWM_NOUT-1:0] phase_all;
    logic [`LPWM_NOUT-1:0] oe_all;
    logic [`LPWM_NOUT-1:0] next_oe;

    assign master_nib = master[`LPWM_MST_MSB:`LPWM_MST_LSB];
    assign global_nib = master[`LPWM_GLB_MSB:`LPWM_GLB_LSB];
    assign phase_all = {extra_phase_bit, phase_output_bit};
    assign pwm_on = master_nib != `LPWM_OFF_CODE;

    // True when the address falls inside the individual register block.
    function automatic logic is_ind(input logic [7:0] a);
        is_ind = a >= `LPWM_ADDR_IND_FIRST && a <= `LPWM_ADDR_IND_LAST;
    endfunction

    // Write side: the master register and eight packed nibble pairs.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            master <= `LPWM_MASTER_RST;
        end else if (wr.en && wr.addr == `LPWM_ADDR_MASTER) begin
            master <= wr.data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int r = 0; r < `LPWM_NREG; r++) begin
                ind[r] <= `LPWM_IND_RST;
            end
        end else if (wr.en && is_ind(wr.addr)) begin
            ind[3'(wr.addr - `LPWM_ADDR_IND_FIRST)] <= wr.data;
        end
    end

    // Read back is registered so the data pins never glitch.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= `LPWM_RD_UNMAPPED;
        end else if (rd.en) begin
            if (rd.addr == `LPWM_ADDR_MASTER) begin
                rd_data <= master;
            end else if (is_ind(rd.addr)) begin
                rd_data <= ind[3'(rd.addr - `LPWM_ADDR_IND_FIRST)];
            end else begin
                rd_data <= `LPWM_RD_UNMAPPED;
            end
        end
    end

    // ****************************************
    // Step timebase
    // ****************************************
    logic [`LPWM_DIV_W-1:0] div;
    logic tick;
    logic [3:0] cyc;
    logic [3:0] slot;

    assign tick = div == STEP_DIV - `LPWM_DIV_W'(1);

    // The divider stands in for the slow oscillator; held idle when
    // PWM is off, which is where the power saving comes from.
    // stop when off
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div <= '0;
        end else if (!pwm_on || tick) begin
            div <= '0;
        end else begin
            div <= div + `LPWM_DIV_W'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cyc <= '0;
            slot <= '0;
        end else if (!pwm_on) begin
            cyc <= '0;
            slot <= '0;
        end else if (tick) begin
            cyc <= cyc + 4'h1;
            if (cyc == `LPWM_CYC_LAST) begin
                slot <= (slot == `LPWM_SLOT_LAST) ? 4'h0 : slot + 4'h1;
            end
        end
    end

    // ****************************************
    // Per-output waveform
    // ****************************************
    logic [`LPWM_NIB_W-1:0] setting [`LPWM_NOUT];

    genvar g;
    generate
        for (g = 0; g < `LPWM_NOUT; g++) begin : g_out
            logic in_gate;
            logic in_low;
            if (g == `LPWM_NPORT) begin : g_extra
                // The extra line always runs from the global nibble.
                assign setting[g] = global_nib;
            end else begin : g_port
                assign setting[g] = global_select ? global_nib :
                    ind[g/2][(g%2)*4 +: 4];
            end
            assign in_gate = slot < master_nib;
            assign in_low = phase_all[g] ? (cyc > setting[g])
                                         : (cyc <= setting[g]);
            // Static cases follow the phase bit; ungated slots release
            // the pin so the output is off outside the master window.
            // static level
            always_comb begin
                if (!pwm_on || setting[g] == `LPWM_STATIC_CODE) begin
                    next_oe[g] = !phase_all[g];
                end else begin
                    next_oe[g] = in_gate && in_low;
                end
            end
        end
    endgenerate

    // Registered drive keeps the pins glitch free across setting changes.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oe_all <= '0;
        end else begin
            oe_all <= next_oe;
        end
    end

    // Open drain: the data level is always low, only the enable moves.
    assign port_line_oe = oe_all[`LPWM_NPORT-1:0];
    assign extra_output_line_oe = oe_all[`LPWM_NPORT];
    assign port_line_out = '0;
    assign extra_output_line_out = 1'b0;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_static_off: assert property (
        !pwm_on |=> port_line_oe == ~$past(phase_output_bit))
        else $error("outputs not static while PWM off");
    chk_cnt_halt: assert property (
        !pwm_on |=> cyc == 4'h0 && slot == 4'h0 && div == '0)
        else $error("step counter runs while PWM off");
    chk_slot_range: assert property (
        slot <= `LPWM_SLOT_LAST)
        else $error("timeslot index out of range");
    chk_slot_wrap: assert property (
        pwm_on && tick && cyc == `LPWM_CYC_LAST &&
        slot == `LPWM_SLOT_LAST |=> slot == 4'h0 && cyc == 4'h0)
        else $error("period does not wrap after 240 steps");
    chk_full_static: assert property (
        pwm_on && setting[0] == `LPWM_STATIC_CODE
        |=> port_line_oe[0] == !$past(phase_output_bit[0]))
        else $error("full-scale output not static");
    chk_low_phase0: assert property (
        pwm_on && setting[0] < `LPWM_STATIC_CODE && slot < master_nib &&
        !phase_output_bit[0] && cyc <= setting[0] |=> port_line_oe[0])
        else $error("phase zero output not low in on-time");
    chk_hiz_phase1: assert property (
        pwm_on && setting[0] < `LPWM_STATIC_CODE &&
        phase_output_bit[0] && cyc <= setting[0] |=> !port_line_oe[0])
        else $error("phase one output not released in on-time");
    chk_gate_slot: assert property (
        pwm_on && setting[0] < `LPWM_STATIC_CODE && slot >= master_nib
        |=> !port_line_oe[0])
        else $error("output active outside master window");
    chk_global_sel: assert property (
        global_select && phase_output_bit[0] == extra_phase_bit
        |=> port_line_oe[0] == extra_output_line_oe)
        else $error("global setting not common to outputs");

    cov_pwm_low: cover property (pwm_on && port_line_oe[0] ##1
        !port_line_oe[0]);
    cov_global: cover property (global_select && pwm_on && tick);
    cov_wrap: cover property (tick && slot == `LPWM_SLOT_LAST &&
        cyc == `LPWM_CYC_LAST);
endmodule
`default_nettype wire

// ---- dv/lpwm_load.sv ----
// Purpose: Pull-up load model for the open-drain port and extra lines.
// Assumes: Each line has a resistive pull-up to the supply.
// Notes: A released line reads high; a driven line reads the drive.
`timescale 1ns/1ps
`default_nettype none
module lpwm_load (
    input wire logic [16:0] oe,
    input wire logic [16:0] drv,
    output logic [16:0] pin
);
    // The pull-up wins whenever the device lets go of the line, so an
    // unknown never survives on a released pin.
    assign pin = ~oe | (oe & drv);
endmodule
`default_nettype wire

// ---- dv/led_port_pwm_intensity_tb_top.sv ----
// Purpose: Self-checking bench for the port PWM intensity generator.
// Assumes: A short step divider keeps one PWM period to 480 clocks.
// Notes: Duty is judged by counting low pin cycles over one period.
`include "lpwm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module led_port_pwm_intensity_tb_top;
    import lpwm_pkg::*;
    localparam logic [15:0] DIV = 16'h0002;
    localparam int PER = 240 * 2;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    lpwm_wr_t wr = '0;
    lpwm_rd_t rd = '0;
    logic [7:0] rd_data;
    logic gsel = 1'b0;
    logic [15:0] ph = '0;
    logic xph = 1'b0;
    logic [15:0] p_out;
    logic [15:0] p_oe;
    logic x_out;
    logic x_oe;
    logic [16:0] pin;
    int fails = 0;
    int samples_checked = 0;
    logic [31:0] lows [17];

    // ****************************************
    // Clock, design and load
    // ****************************************
    // The clock toggles every 2 ns, half of its 4 ns period.
    always #2 clk = ~clk;

    lpwm_core #(.STEP_DIV(DIV)) i_lpwm_core (.clk(clk), .nrst(nrst),
        .wr(wr), .rd(rd), .rd_data(rd_data), .global_select(gsel),
        .phase_output_bit(ph), .extra_phase_bit(xph),
        .port_line_out(p_out), .port_line_oe(p_oe),
        .extra_output_line_out(x_out), .extra_output_line_oe(x_oe));

    lpwm_load i_lpwm_load (.oe({x_oe, p_oe}), .drv({x_out, p_out}),
        .pin(pin));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A write is held for exactly one rising edge.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) wr = '{en: 1'b1, addr: a, data: d};
        @(negedge clk) wr.en = 1'b0;
    endtask

    // Read data is registered, so it is settled by the next falling edge.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk) rd = '{en: 1'b1, addr: a};
        @(negedge clk) rd.en = 1'b0;
        check("read data", {24'h0, rd_data}, {24'h0, exp});
    endtask

    // Low cycles per period for master m, setting n and phase bit p.
    function automatic logic [31:0] exp_low(input logic [3:0] m,
        input logic [3:0] n, input logic p);
        if (m == 4'h0 || n == 4'hf) return p ? 32'h0 : 32'(PER);
        return p ? 32'((15 - n) * m * DIV) : 32'((n + 1) * m * DIV);
    endfunction

    // ****************************************
    // Scenarios
    // ****************************************
    // Reset values, an unmapped place and a read-back of the last setting register.
    task automatic t_regs();
        rd_chk(`LPWM_ADDR_MASTER, 8'h00); // reset master
        rd_chk(`LPWM_ADDR_IND_FIRST, 8'hff); // reset setting
        wr_reg(8'h0f, 8'h5a);
        rd_chk(8'h0f, 8'h00); // unmapped place
        for (int k = 0; k < 8; k++) begin
            wr_reg(`LPWM_ADDR_IND_FIRST + 8'(k), {4'(2 * k + 1), 4'(2 * k)});
        end
        rd_chk(`LPWM_ADDR_IND_LAST, 8'hfe); // setting read-back
        $display("test registers done");
    endtask

    // With global clear, port i carries setting i, so all sixteen codes are seen at once;
    // the window may start mid-period because the pattern repeats.
    task automatic run_cfg(input string name, input logic [7:0] mst,
                           input logic g, input logic p);
        logic [3:0] n;
        wr_reg(`LPWM_ADDR_MASTER, mst);
        @(negedge clk) gsel = g;
        ph = p ? 16'haaaa : 16'h5555;
        xph = p;
        repeat (4) @(negedge clk);
        foreach (lows[i]) lows[i] = '0;
        repeat (PER) begin
            @(negedge clk);
            foreach (lows[i]) if (pin[i] === 1'b0) lows[i]++;
        end
        for (int i = 0; i < 17; i++) begin
            n = (g || i == 16) ? mst[3:0] : 4'(i);
            check(name, lows[i], exp_low(mst[7:4], n, i == 16 ? p : ph[i]));
        end
        $display("test %s done", name);
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    // Reset is held for five clocks and released off the rising edge.
    initial begin
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        t_regs();
        run_cfg("master off", 8'h0c, 1'b1, 1'b0);
        run_cfg("individual", 8'h35, 1'b0, 1'b0);
        run_cfg("one slot", 8'h1e, 1'b0, 1'b1);
        run_cfg("global", 8'hf9, 1'b1, 1'b1);
        run_cfg("global full", 8'h7f, 1'b1, 1'b0);
        summarize();
    end

    // Five periods of tests fit well inside twenty periods plus slack.
    initial begin
        repeat (20 * PER + 2000) @(posedge clk);
        fails++;
        summarize();
    end
endmodule
`default_nettype wire
